/* common/rtc_pkg.sv */
// constants and carrier types for the parallel rtc supervisor
package rtc_pkg;
  // clock and crystal rates
  localparam int unsigned CLK_HZ     = 125_000_000;
  localparam int unsigned CLK_NS     = 8;
  localparam int unsigned XTAL_HZ    = 32_768;
  // timing figures in their own units
  localparam int unsigned HOLD_MS    = 200;
  localparam int unsigned CE_HOLD_US = 100;
  localparam int unsigned WARN_NS    = 64;
  localparam int unsigned WD_MS      = 1500;
  // derived counts, in mclk cycles or crystal ticks
  localparam int unsigned HOLD_CYC    = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned CE_HOLD_CYC = CE_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WARN_CYC    = WARN_NS / CLK_NS;
  localparam int unsigned WD_TICKS    = WD_MS * XTAL_HZ / 1000;
  localparam int unsigned SEC_TICKS   = XTAL_HZ;
  // register indices
  localparam logic [3:0] A_SEC    = 4'h0;
  localparam logic [3:0] A_SEC_AL = 4'h1;
  localparam logic [3:0] A_MIN    = 4'h2;
  localparam logic [3:0] A_MIN_AL = 4'h3;
  localparam logic [3:0] A_HR     = 4'h4;
  localparam logic [3:0] A_HR_AL  = 4'h5;
  localparam logic [3:0] A_DAY    = 4'h6;
  localparam logic [3:0] A_DAY_AL = 4'h7;
  localparam logic [3:0] A_DOW    = 4'h8;
  localparam logic [3:0] A_MON    = 4'h9;
  localparam logic [3:0] A_YR     = 4'hA;
  localparam logic [3:0] A_RATE   = 4'hB;
  localparam logic [3:0] A_IEN    = 4'hC;
  localparam logic [3:0] A_FLAG   = 4'hD;
  localparam logic [3:0] A_CTRL   = 4'hE;
  // field positions
  localparam int WD_LSB    = 4;
  localparam int AIE_B     = 3;
  localparam int PIE_B     = 2;
  localparam int PWRIE_B   = 1;
  localparam int ABE_B     = 0;
  localparam int STOP_B    = 2;
  localparam int ALM_IGN_B = 7;
  // values after reset
  localparam logic [6:0] RATE_RST = 7'h00;
  localparam logic [3:0] IEN_RST  = 4'h2;
  localparam logic [3:0] CTRL_RST = 4'h6;
  typedef enum logic [1:0] {
    WD_MID = 2'b00, WD_LO = 2'b01, WD_HI = 2'b10, WD_BAD = 2'b11
  } wd_lvl_t;
  typedef enum logic [1:0] {
    P_UP = 2'b00, P_WARN = 2'b01, P_FAIL = 2'b10, P_HOLD = 2'b11
  } pwr_st_t;
  typedef struct packed {
    logic [7:0] yr, mo, dow, dy, hr, mn, sc;
  } time_t;
  localparam time_t TM_RST = '{yr: 8'h00, mo: 8'h01, dow: 8'h01, dy: 8'h01,
                               hr: 8'h00, mn: 8'h00, sc: 8'h00};
  typedef struct packed {
    logic       cs_n;
    logic       oe_n;
    logic       we_n;
    logic [3:0] reg_index;
    logic [7:0] bus_data;
  } bus_pins_t;
  localparam bus_pins_t BUS_IDLE = '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                     reg_index: 4'h0, bus_data: 8'h00};
endpackage

/* hw/pin_sync.sv */
// three-stage pin synchroniser with stage agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned   W    = 1,
  parameter logic [W-1:0]  INIT = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic [W-1:0]      q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_st_t;
  sync_st_t s_q;
  sync_st_t s_d;

  // a bit changes only once the second and third stages agree
  always_comb begin
    s_d    = s_q;
    s_d.s1 = d_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.q  = (s_q.s2 & s_q.s3) | (s_q.q & (s_q.s2 ^ s_q.s3));
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.q;
endmodule

/* hw/bcd_step.sv */
// two-digit bcd step with wrap from the top value to the bottom one
`timescale 1ns/1ps
module bcd_step (
  input  wire logic       en_i,
  input  wire logic [7:0] v_i,
  input  wire logic [7:0] lo_i,
  input  wire logic [7:0] hi_i,
  output logic [7:0]      nx_o,
  output logic            wrap_o
);
  logic [7:0] inc;

  // ones digit rolls into tens at nine
  always_comb begin
    if (v_i[3:0] == 4'h9) begin
      inc = {v_i[7:4] + 4'h1, 4'h0};
    end else begin
      inc = {v_i[7:4], v_i[3:0] + 4'h1};
    end
    wrap_o = en_i && (v_i >= hi_i);
    if (!en_i) begin
      nx_o = v_i;
    end else if (wrap_o) begin
      nx_o = lo_i;
    end else begin
      nx_o = inc;
    end
  end
endmodule

/* hw/parallel_rtc_cpu_supervisor.sv */
// real-time clock with power, watchdog and ram-select supervision
// Operation
// - time of day and date, seconds to years, every field in bcd
// - hundred-year calendar, two-digit year wraps 99 to 00
// - time base is the 32.768 khz crystal, 32768 ticks a second
// - on supply loss the interrupt goes low first, the cpu reset after
// - cpu reset held low while supply is below threshold
// - cpu reset held a further 200 ms after supply returns
// - watchdog expiry also pulls the cpu reset low
// - interrupt low on power-fail, periodic or alarm event
// - watchdog output low when kick input steady past timeout, 1.5 s default
// - expired watchdog stays low until next kick edge, then restarts
// - kick input is three-level; mid level disables the watchdog
// - watchdog timeout set by software, independent of the clock
// - alarm repeats from each second to monthly by field matching
// - alarm optionally active while running from the battery
// - periodic interrupt from 30.5 us to 500 ms off the crystal
// - gated ram select low only with select low and supply good, or in the power-fail grace window
// - on power fail gated select stays low 100 us or until release
// - four index inputs pick one of fifteen byte registers, index f reads zero
// - eight-bit two-way data bus shared with the memory bus
// - data driven only while selected, output-enabled, strobe high
// - write when selected and strobe low, whatever output enable
// - accesses ignored under power fail, ram select held off once the grace window ends
// - leap years corrected at the end of february
// - day of week runs sunday 1 to saturday 7, wraps to 1
`timescale 1ns/1ps
module parallel_rtc_cpu_supervisor #(
  parameter int unsigned HOLD_CYCLES    = rtc_pkg::HOLD_CYC,
  parameter int unsigned CE_HOLD_CYCLES = rtc_pkg::CE_HOLD_CYC,
  parameter int unsigned WD_BASE_TICKS  = rtc_pkg::WD_TICKS,
  parameter int unsigned SEC_TICKS      = rtc_pkg::SEC_TICKS
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  input  wire rtc_pkg::bus_pins_t bus_i,
  output logic [7:0]              bus_data_o,
  output logic                    bus_data_oe_n_o,
  input  wire logic               crystal_pins_i,
  input  wire rtc_pkg::wd_lvl_t   watchdog_kick_in_i,
  input  wire logic               supply_ok_i,
  input  wire logic               battery_ok_i,
  input  wire logic               ram_sel_n_i,
  output logic                    ram_sel_n_o,
  output logic                    cpu_rst_oe_n_o,
  output logic                    int_oe_n_o,
  output logic                    watchdog_expired_n_o
);
  import rtc_pkg::*;

  localparam int WDW = $clog2(WD_BASE_TICKS + 1);
  localparam int PCW = $clog2(HOLD_CYCLES + 1);
  localparam int CEW = $clog2(CE_HOLD_CYCLES + 1);
  localparam int SCW = $clog2(SEC_TICKS + 1);

  typedef struct packed {
    time_t      tm;
    logic [7:0] al_sc;
    logic [7:0] al_mn;
    logic [7:0] al_hr;
    logic [7:0] al_dy;
    logic [6:0] rate;
    logic [3:0] ien;
    logic       af;
    logic       pf;
    logic       pwrf;
    logic [3:0] ctrl;
    logic [SCW-1:0] scnt;
    logic [14:0]    pcnt;
    logic [WDW-1:0] wcnt;
    wd_lvl_t        wlast;
    logic           wdo_n;
    pwr_st_t        pst;
    logic [PCW-1:0] hcnt;
    logic           ce_n;
    logic           ce_hold;
    logic [CEW-1:0] ccnt;
    logic           pok_l;
    logic           xt_l;
    logic           wr_l;
    logic           rd_l;
    logic [3:0]     ridx;
    logic [3:0]     widx;
    logic [7:0]     wdat;
    logic [7:0]     dout;
    logic           drv;
  } core_st_t;

  localparam core_st_t ST_RST = '{tm: TM_RST, rate: RATE_RST, ien: IEN_RST,
                                  ctrl: CTRL_RST, wlast: WD_MID, wdo_n: 1'b1,
                                  pst: P_HOLD, ce_n: 1'b1, default: '0};

  core_st_t   s_q;
  core_st_t   s_d;
  bus_pins_t  bus;
  logic [5:0] misc;
  logic       xt;
  wd_lvl_t    lvl;
  logic       pok;
  logic       bat_ok;
  logic       rsel_n;

  // every outside pin passes the three-stage filter first
  pin_sync #(.W(15), .INIT(BUS_IDLE)) u_bus_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    (bus_i),
    .q_o    (bus)
  );
  pin_sync #(.W(6), .INIT(6'h01)) u_misc_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({crystal_pins_i, watchdog_kick_in_i, supply_ok_i, battery_ok_i,
              ram_sel_n_i}),
    .q_o    (misc)
  );
  assign xt     = misc[5];
  assign lvl    = wd_lvl_t'(misc[4:3]);
  assign pok    = misc[2];
  assign bat_ok = misc[1];
  assign rsel_n = misc[0];

  // crystal edge and the second boundary
  logic xt_tick;
  logic sec_tick;
  assign xt_tick  = xt && !s_q.xt_l;
  assign sec_tick = xt_tick && s_q.ctrl[STOP_B] && (s_q.scnt == SCW'(SEC_TICKS - 1));

  // february length from the bcd year, 00 counts as a leap year
  function automatic logic [7:0] days_in(input logic [7:0] mo, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mo)
      8'h02:                      days_in = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in = 8'h30;
      default:                    days_in = 8'h31;
    endcase
  endfunction

  // calendar ripple; each stage steps when the one below wraps
  logic [7:0] n_sc;
  logic [7:0] n_mn;
  logic [7:0] n_hr;
  logic [7:0] n_dy;
  logic [7:0] n_mo;
  logic [7:0] n_yr;
  logic [7:0] n_dw;
  logic       c_sc;
  logic       c_mn;
  logic       c_hr;
  logic       c_dy;
  logic       c_mo;

  bcd_step u_sc (.en_i(sec_tick), .v_i(s_q.tm.sc), .lo_i(8'h00), .hi_i(8'h59),
                 .nx_o(n_sc), .wrap_o(c_sc));
  bcd_step u_mn (.en_i(c_sc), .v_i(s_q.tm.mn), .lo_i(8'h00), .hi_i(8'h59),
                 .nx_o(n_mn), .wrap_o(c_mn));
  bcd_step u_hr (.en_i(c_mn), .v_i(s_q.tm.hr), .lo_i(8'h00), .hi_i(8'h23),
                 .nx_o(n_hr), .wrap_o(c_hr));
  bcd_step u_dy (.en_i(c_hr), .v_i(s_q.tm.dy), .lo_i(8'h01),
                 .hi_i(days_in(s_q.tm.mo, s_q.tm.yr)), .nx_o(n_dy), .wrap_o(c_dy));
  bcd_step u_dw (.en_i(c_hr), .v_i(s_q.tm.dow), .lo_i(8'h01), .hi_i(8'h07),
                 .nx_o(n_dw), .wrap_o());
  bcd_step u_mo (.en_i(c_dy), .v_i(s_q.tm.mo), .lo_i(8'h01), .hi_i(8'h12),
                 .nx_o(n_mo), .wrap_o(c_mo));
  bcd_step u_yr (.en_i(c_mo), .v_i(s_q.tm.yr), .lo_i(8'h00), .hi_i(8'h99),
                 .nx_o(n_yr), .wrap_o());

  // alarm fields are skipped when their ignore bit is set
  logic al_hit;
  assign al_hit = (s_q.al_sc[ALM_IGN_B] || s_q.al_sc[6:0] == n_sc[6:0])
               && (s_q.al_mn[ALM_IGN_B] || s_q.al_mn[6:0] == n_mn[6:0])
               && (s_q.al_hr[ALM_IGN_B] || s_q.al_hr[6:0] == n_hr[6:0])
               && (s_q.al_dy[ALM_IGN_B] || s_q.al_dy[6:0] == n_dy[6:0]);

  // periodic event: rate n gives a period of 2^(n-1) crystal ticks
  logic [14:0] per_mask;
  logic        per_hit;
  assign per_mask = (15'h0001 << (s_q.rate[3:0] - 4'h1)) - 15'h0001;
  assign per_hit  = xt_tick && (s_q.rate[3:0] != 4'h0)
                 && ((s_q.pcnt & per_mask) == 15'h0000);

  // bus strobes, already synchronised; power loss shuts the bus out
  logic rd_act;
  logic wr_raw;
  logic wr_done;
  logic rd_done;
  assign rd_act  = pok && !bus.cs_n && !bus.oe_n && bus.we_n;
  assign wr_raw  = !bus.cs_n && !bus.we_n;
  assign wr_done = s_q.wr_l && !wr_raw && pok;
  assign rd_done = s_q.rd_l && !rd_act;

  // watchdog limit shrinks by halves as the rate field grows
  logic [WDW-1:0] wd_lim;
  logic           wd_edge;
  assign wd_lim  = WDW'(WD_BASE_TICKS >> s_q.rate[6:WD_LSB]) - WDW'(1);
  assign wd_edge = (lvl == WD_LO || lvl == WD_HI) && lvl != s_q.wlast;

  // read value mux; unused bits read as zero
  function automatic logic [7:0] rd_val(input core_st_t s, input logic [3:0] i,
                                        input logic b);
    case (i)
      A_SEC:    rd_val = s.tm.sc;
      A_SEC_AL: rd_val = s.al_sc;
      A_MIN:    rd_val = s.tm.mn;
      A_MIN_AL: rd_val = s.al_mn;
      A_HR:     rd_val = s.tm.hr;
      A_HR_AL:  rd_val = s.al_hr;
      A_DAY:    rd_val = s.tm.dy;
      A_DAY_AL: rd_val = s.al_dy;
      A_DOW:    rd_val = s.tm.dow;
      A_MON:    rd_val = s.tm.mo;
      A_YR:     rd_val = s.tm.yr;
      A_RATE:   rd_val = {1'b0, s.rate};
      A_IEN:    rd_val = {4'h0, s.ien};
      A_FLAG:   rd_val = {4'h0, s.af, s.pf, s.pwrf, b};
      A_CTRL:   rd_val = {4'h0, s.ctrl};
      default:  rd_val = 8'h00;
    endcase
  endfunction

  always_comb begin
    s_d       = s_q;
    s_d.xt_l  = xt;
    s_d.pok_l = pok;
    s_d.wr_l  = wr_raw;
    s_d.rd_l  = rd_act;

    // tick counters; the periodic one never stops
    if (xt_tick) begin
      s_d.pcnt = s_q.pcnt + 15'h0001;
      s_d.scnt = (s_q.scnt == SCW'(SEC_TICKS - 1)) ? '0 : s_q.scnt + SCW'(1);
    end

    // time advance, then a finished write overrides its field
    s_d.tm = '{yr: n_yr, mo: n_mo, dow: n_dw, dy: n_dy, hr: n_hr, mn: n_mn, sc: n_sc};
    if (s_q.wr_l && wr_raw) begin
      s_d.widx = bus.reg_index;
      s_d.wdat = bus.bus_data;
    end
    if (wr_done) begin
      case (s_q.widx)
        A_SEC:    s_d.tm.sc  = s_q.wdat;
        A_SEC_AL: s_d.al_sc  = s_q.wdat;
        A_MIN:    s_d.tm.mn  = s_q.wdat;
        A_MIN_AL: s_d.al_mn  = s_q.wdat;
        A_HR:     s_d.tm.hr  = s_q.wdat;
        A_HR_AL:  s_d.al_hr  = s_q.wdat;
        A_DAY:    s_d.tm.dy  = s_q.wdat;
        A_DAY_AL: s_d.al_dy  = s_q.wdat;
        A_DOW:    s_d.tm.dow = s_q.wdat;
        A_MON:    s_d.tm.mo  = s_q.wdat;
        A_YR:     s_d.tm.yr  = s_q.wdat;
        A_RATE:   s_d.rate   = s_q.wdat[6:0];
        A_IEN:    s_d.ien    = s_q.wdat[3:0];
        A_CTRL:   s_d.ctrl   = s_q.wdat[3:0];
        default:  s_d.ctrl   = s_q.ctrl;
      endcase
    end

    // reading the flag byte clears it; a new event in that cycle wins
    if (rd_done && s_q.ridx == A_FLAG) begin
      s_d.af   = 1'b0;
      s_d.pf   = 1'b0;
      s_d.pwrf = 1'b0;
    end
    if (sec_tick && al_hit && (pok || s_q.ien[ABE_B])) begin
      s_d.af = 1'b1;
    end
    if (per_hit) begin
      s_d.pf = 1'b1;
    end

    // watchdog runs on crystal ticks, apart from the calendar
    if (lvl == WD_MID || lvl == WD_BAD) begin
      s_d.wdo_n = 1'b1;
      s_d.wcnt  = '0;
    end else if (wd_edge) begin
      s_d.wdo_n = 1'b1;
      s_d.wcnt  = '0;
      s_d.wlast = lvl;
    end else if (xt_tick && s_q.wdo_n) begin
      if (s_q.wcnt >= wd_lim) begin
        s_d.wdo_n = 1'b0;
      end else begin
        s_d.wcnt = s_q.wcnt + WDW'(1);
      end
    end

    // supply supervisor: warn, then reset, then hold after return
    unique case (s_q.pst)
      P_UP: begin
        if (!pok) begin
          s_d.pst  = P_WARN;
          s_d.hcnt = '0;
          s_d.pwrf = 1'b1;
        end
      end
      P_WARN: begin
        s_d.hcnt = s_q.hcnt + PCW'(1);
        if (s_q.hcnt == PCW'(WARN_CYC - 1)) begin
          s_d.pst = P_FAIL;
        end
      end
      P_FAIL: begin
        s_d.hcnt = '0;
        if (pok) begin
          s_d.pst = P_HOLD;
        end
      end
      P_HOLD: begin
        s_d.hcnt = s_q.hcnt + PCW'(1);
        if (!pok) begin
          s_d.pst = P_FAIL;
        end else if (s_q.hcnt == PCW'(HOLD_CYCLES - 1)) begin
          s_d.pst = P_UP;
        end
      end
    endcase

    // ram select gating with a short grace window on power loss
    if (pok) begin
      s_d.ce_n    = rsel_n;
      s_d.ce_hold = 1'b0;
      s_d.ccnt    = '0;
    end else if (s_q.pok_l) begin
      s_d.ce_hold = !rsel_n && !s_q.ce_n;
      s_d.ce_n    = rsel_n || s_q.ce_n;
    end else if (s_q.ce_hold) begin
      s_d.ccnt = s_q.ccnt + CEW'(1);
      if (rsel_n || s_q.ccnt == CEW'(CE_HOLD_CYCLES - 1)) begin
        s_d.ce_hold = 1'b0;
        s_d.ce_n    = 1'b1;
      end
    end else begin
      s_d.ce_n = 1'b1;
    end

    // read data from flip-flops; index follows the bus while reading
    s_d.drv = rd_act;
    if (rd_act) begin
      s_d.ridx = bus.reg_index;
      s_d.dout = rd_val(s_q, bus.reg_index, bat_ok);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // pin outputs; the open-drain pins are enable-only
  assign bus_data_o           = s_q.dout;
  assign bus_data_oe_n_o      = !s_q.drv;
  assign ram_sel_n_o          = s_q.ce_n;
  assign watchdog_expired_n_o = s_q.wdo_n;
  assign cpu_rst_oe_n_o       = !(s_q.pst == P_FAIL || s_q.pst == P_HOLD || !s_q.wdo_n);
  assign int_oe_n_o = !((s_q.af && s_q.ien[AIE_B]) || (s_q.pf && s_q.ien[PIE_B])
                     || (s_q.pwrf && s_q.ien[PWRIE_B]));

  // checks on the supervisor behaviour
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_pwr_drop;
    s_q.pst == P_UP && !pok;
  endsequence
  sequence s_warn_span;
    (s_q.pst == P_WARN)[*8] ##1 (s_q.pst == P_FAIL);
  endsequence

  a_warn_span: assert property (s_pwr_drop |=> s_warn_span)
    else $error("warning phase length wrong");
  a_warn_no_rst: assert property (s_q.pst == P_WARN && s_q.wdo_n |-> cpu_rst_oe_n_o)
    else $error("reset driven during warning");
  a_fail_rst: assert property (!pok && s_q.pst != P_UP && s_q.pst != P_WARN
                               |=> !cpu_rst_oe_n_o)
    else $error("reset released while supply low");
  a_hold_stay: assert property (s_q.pst == P_HOLD && pok
                                && s_q.hcnt < PCW'(HOLD_CYCLES - 1) |=> s_q.pst == P_HOLD)
    else $error("reset hold ended early");
  a_wd_rst: assert property ($fell(watchdog_expired_n_o) |-> !cpu_rst_oe_n_o)
    else $error("watchdog expiry did not reset");
  a_wd_mid: assert property (lvl == WD_MID |=> watchdog_expired_n_o ##1 s_q.wcnt == '0)
    else $error("mid level did not disable watchdog");
  a_wd_edge: assert property (!s_q.wdo_n && wd_edge |=> s_q.wdo_n && s_q.wcnt == '0)
    else $error("kick edge did not restart watchdog");
  a_pf_int: assert property (per_hit && s_q.ien[PIE_B] |=> !int_oe_n_o)
    else $error("periodic event not on interrupt");
  a_bus_hiz: assert property (!rd_act |=> bus_data_oe_n_o)
    else $error("bus driven outside a read");
  a_ram_gate: assert property (!ram_sel_n_o && !s_q.ce_hold |-> $past(pok && !rsel_n))
    else $error("ram select low without cause");
  a_dow_wrap: assert property (c_hr && s_q.tm.dow == 8'h07 && !wr_done
                               |=> s_q.tm.dow == 8'h01)
    else $error("day of week did not wrap");
endmodule

/* tb/host_model.sv */
// host processor model on the rtc's sram-style pins
`timescale 1ns/1ps
module host_model
  import rtc_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic [7:0] dev_data_i,
  input  wire logic       dev_oe_n_i,
  output rtc_pkg::bus_pins_t bus_o
);
  bus_pins_t  p = BUS_IDLE;
  logic       drv = 1'b0;
  logic [7:0] last = 8'h00;
  // shared data wire; a released bus shows a changing pattern, not stale data
  always_comb begin
    bus_o = p;
    bus_o.bus_data = !dev_oe_n_i ? dev_data_i : drv ? p.bus_data : ~last;
  end
  always_ff @(posedge mclk_i) last <= bus_o.bus_data;
  // strobes held 8 cycles low, 6 high: the pin filter needs at least 2 each
  task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic oe_n);
    @(posedge mclk_i);
    #1 p.reg_index = idx;
    p.bus_data = d;
    drv = 1'b1;
    p.cs_n = 1'b0;
    p.we_n = 1'b0;
    p.oe_n = oe_n;
    repeat (8) @(posedge mclk_i);
    #1 p.cs_n = 1'b1;
    p.we_n = 1'b1;
    p.oe_n = 1'b1;
    repeat (6) @(posedge mclk_i);
    #1 drv = 1'b0;
  endtask
  // read with write strobe high; an undriven bus returns unknown
  task automatic rd(input logic [3:0] idx, output logic [7:0] d);
    @(posedge mclk_i);
    #1 p.reg_index = idx;
    p.cs_n = 1'b0;
    p.oe_n = 1'b0;
    for (int i = 0; i < 12 && dev_oe_n_i !== 1'b0; i++) @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    // take the byte once this edge has settled, then release
    #1 d = (dev_oe_n_i === 1'b0) ? dev_data_i : 8'hxx;
    p.cs_n = 1'b1;
    p.oe_n = 1'b1;
    repeat (8) @(posedge mclk_i);
  endtask
endmodule

/* tb/tb_parallel_rtc_cpu_supervisor.sv */
// self-checking bench for the parallel rtc supervisor
`timescale 1ns/1ps
module tb_parallel_rtc_cpu_supervisor;
  import rtc_pkg::*;
  localparam int HOLD = 50;
  localparam int CEH  = 20;
  logic       mclk, rst, xtal, sup, bat, ram_n;
  logic       doe_n, ram_o, cpu_rst_n, int_n, wdo_n;
  logic [7:0] dout, rd_v;
  logic [3:0] outs;
  wd_lvl_t    kick;
  bus_pins_t  bus;
  int         n_errors = 0;
  int         n_tests = 0;
  host_model host (.mclk_i(mclk), .dev_data_i(dout), .dev_oe_n_i(doe_n), .bus_o(bus));
  parallel_rtc_cpu_supervisor #(.HOLD_CYCLES(HOLD), .CE_HOLD_CYCLES(CEH),
    .WD_BASE_TICKS(8), .SEC_TICKS(4)) dut (.mclk_i(mclk), .rst_i(rst), .bus_i(bus),
    .bus_data_o(dout), .bus_data_oe_n_o(doe_n), .crystal_pins_i(xtal),
    .watchdog_kick_in_i(kick), .supply_ok_i(sup), .battery_ok_i(bat),
    .ram_sel_n_i(ram_n), .ram_sel_n_o(ram_o), .cpu_rst_oe_n_o(cpu_rst_n),
    .int_oe_n_o(int_n), .watchdog_expired_n_o(wdo_n));
  assign outs = {ram_o, wdo_n, cpu_rst_n, int_n};
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // crystal stand-in, one tick each 40 mclk so a second is 160 cycles
  always begin
    repeat (20) @(posedge mclk);
    #1 xtal = ~xtal;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for an output level, then judge it
  task automatic till(input string what, input int s, input logic v, input int n);
    for (int i = 0; i < n && outs[s] !== v; i++) @(posedge mclk);
    chk(what, {7'h00, v}, {7'h00, outs[s]});
  endtask
  task automatic at(input string what, input int s, input logic v, input int n);
    repeat (n) @(posedge mclk);
    chk(what, {7'h00, v}, {7'h00, outs[s]});
  endtask
  task automatic results;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_reset;
    at("rst held", 1, 1'b0, HOLD - 15);
    till("rst released", 1, 1'b1, 30);
    host.rd(A_IEN, rd_v);
    chk("ien", 8'h02, rd_v);
    host.rd(A_CTRL, rd_v);
    chk("ctrl", 8'h06, rd_v);
    host.rd(A_RATE, rd_v);
    chk("rate", 8'h00, rd_v);
  endtask
  task automatic t_regs;
    host.wr(A_MIN_AL, 8'h45, 1'b1);
    host.wr(A_SEC_AL, 8'h30, 1'b0);
    host.wr(4'hF, 8'h55, 1'b1);
    host.rd(A_MIN_AL, rd_v);
    chk("min alarm", 8'h45, rd_v);
    host.rd(A_SEC_AL, rd_v);
    chk("sec alarm", 8'h30, rd_v);
    host.rd(4'hF, rd_v);
    chk("unused", 8'h00, rd_v);
  endtask
  // year end and leap day, each one second before midnight
  task automatic t_cal;
    for (int k = 0; k < 2; k++) begin
      host.wr(A_YR, k ? 8'h24 : 8'h99, 1'b1);
      host.wr(A_MON, k ? 8'h02 : 8'h12, 1'b1);
      host.wr(A_DAY, k ? 8'h28 : 8'h31, 1'b1);
      host.wr(A_DOW, k ? 8'h03 : 8'h07, 1'b1);
      host.wr(A_HR, 8'h23, 1'b1);
      host.wr(A_MIN, 8'h59, 1'b1);
      host.wr(A_SEC, 8'h59, 1'b1);
      repeat (250) @(posedge mclk);
      host.rd(A_YR, rd_v);
      chk("year", k ? 8'h24 : 8'h00, rd_v);
      host.rd(A_MON, rd_v);
      chk("month", 8'h01 + 8'(k), rd_v);
      host.rd(A_DAY, rd_v);
      chk("day", k ? 8'h29 : 8'h01, rd_v);
      host.rd(A_DOW, rd_v);
      chk("dow", k ? 8'h04 : 8'h01, rd_v);
    end
  endtask
  task automatic t_power;
    #1 ram_n = 1'b0;
    @(posedge mclk);
    #1 sup = 1'b0;
    till("int warn", 0, 1'b0, 8);
    chk("rst after int", 8'h01, {7'h00, cpu_rst_n});
    till("rst fail", 1, 1'b0, 16);
    at("ram sel held", 3, 1'b0, 2);
    till("ram sel cut", 3, 1'b1, CEH);
    host.rd(A_MIN, rd_v);
    chk("read refused", 8'hxx, rd_v);
    #1 ram_n = 1'b1;
    at("rst low", 1, 1'b0, 30);
    #1 sup = 1'b1;
    at("rst hold", 1, 1'b0, HOLD - 10);
    till("rst up", 1, 1'b1, 20);
    host.rd(A_FLAG, rd_v);
    chk("pwr flag", 8'h03, rd_v & 8'h03);
    at("int cleared", 0, 1'b1, 4);
    #1 ram_n = 1'b0;
    till("ram sel pass", 3, 1'b0, 8);
    #1 ram_n = 1'b1;
  endtask
  // rate 1 gives a periodic event on every crystal tick
  task automatic t_per;
    host.wr(A_IEN, 8'h06, 1'b1);
    host.wr(A_RATE, 8'h01, 1'b1);
    till("per int", 0, 1'b0, 60);
    host.rd(A_FLAG, rd_v);
    chk("per flag", 8'h04, rd_v & 8'h04);
    host.wr(A_RATE, 8'h00, 1'b1);
    host.rd(A_FLAG, rd_v);
    at("per int off", 0, 1'b1, 4);
  endtask
  // the host holds the kick line low until expiry, a high kick restarts it, mid level disables
  task automatic t_wdog;
    host.wr(A_RATE, 8'h10, 1'b1);
    #1 kick = WD_LO;
    at("wdo early", 2, 1'b1, 100);
    till("wdo expiry", 2, 1'b0, 150);
    till("rst on wdog", 1, 1'b0, 4);
    #1 kick = WD_HI;
    till("wdo restart", 2, 1'b1, 60);
    at("wdo rearmed", 2, 1'b1, 80);
    #1 kick = WD_MID;
    at("wdo off", 2, 1'b1, 500);
  endtask
  initial begin
    rst = 1'b1;
    sup = 1'b1;
    bat = 1'b1;
    ram_n = 1'b1;
    xtal = 1'b0;
    kick = WD_MID;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    t_reset;
    t_regs;
    t_cal;
    t_power;
    t_per;
    t_wdog;
    results;
  end
  // watchdog on the run itself, well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    results;
  end
endmodule
